// File: pkg/ebr_defs.vh
/*
 External bus read cycle: constants for the read sequencer.
 Assumes a 20 MHz processor clock; no software registers.
*/
`ifndef EBR_DEFS_VH
`define EBR_DEFS_VH
`define EBR_ADDR_W 14
`define EBR_DATA_W 16
`define EBR_WAIT_W 4
`define EBR_WAIT_MAX 4'hF
`define EBR_SPACE_BOOT 2'h0
`define EBR_SPACE_PROG 2'h1
`define EBR_SPACE_DATA 2'h2
`define EBR_SPACE_IO 2'h3
`define EBR_SEL_IDLE 4'hF
`define EBR_CLK_NS 50
`define EBR_SETUP_CYC 1
`define EBR_BUF_DEPTH 2
`endif

// File: src/ebr_buf.v
/*
 Two-entry buffer with valid/ready on both sides.
 Assumes one clock and an already synchronised active-low reset.
*/
`timescale 1ns/10ps
module ebr_buf #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem0;
    reg [WIDTH-1:0] mem1;
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = rd_ptr ? mem1 : mem0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem0 <= {WIDTH{1'b0}};
            mem1 <= {WIDTH{1'b0}};
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                if (wr_ptr)
                    mem1 <= in_data;
                else
                    mem0 <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // ebr_buf

// File: src/ebr_read.v
/*
 External parallel bus read sequencer with per-space wait states.
 Assumes a memory-mapped peripheral behind an external decoder; the
 peripheral drives data only while the read strobe is low.
*/
`timescale 1ns/10ps
`include "ebr_defs.vh"
// Behaviour
// - Address and space select driven together
// - Program/data buses share external buses
// - Four active-low selects, exactly one asserted during an access, none when idle
// - Data captured on strobe rising edge
// - Strobe low half cycle plus waits (the code holds it low one whole cycle plus waits)
// - Per-space wait states zero to fifteen
// - Each wait adds one clock period
// - Address, select, strobe held during waits
module ebr_read #(
    parameter AW = `EBR_ADDR_W,
    parameter DW = `EBR_DATA_W
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Wait-state configuration per space
    input wire [`EBR_WAIT_W-1:0] boot_waits,
    input wire [`EBR_WAIT_W-1:0] prog_waits,
    input wire [`EBR_WAIT_W-1:0] data_waits,
    input wire [`EBR_WAIT_W-1:0] io_waits,
    // Conversion-complete request
    input wire irq_n,
    // Internal read requests: program and data address buses
    input wire req_valid,
    output reg req_ready,
    input wire [1:0] req_space,
    input wire req_from_prog,
    input wire [AW-1:0] prog_addr,
    input wire [AW-1:0] data_addr,
    // Address used when servicing the request line
    input wire [AW-1:0] irq_addr,
    input wire [1:0] irq_space,
    // External bus
    output reg [AW-1:0] ext_addr,
    input wire [DW-1:0] ext_data_in,
    output reg rd_n,
    output reg boot_space_select_n,
    output reg program_space_select_n,
    output reg data_space_select_n,
    output reg io_space_select_n,
    // Read data out
    output reg rdata_valid,
    input wire rdata_ready,
    output reg [DW-1:0] rdata,
    output reg rdata_from_irq
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SETUP = 2'h1;
    localparam ST_STROBE = 2'h2;
    localparam ST_DONE = 2'h3;

    reg rst_s1;
    reg rst_n;
    reg [1:0] state;
    reg [`EBR_WAIT_W-1:0] wait_cnt;
    reg irq_d;
    reg irq_pend;
    reg cur_irq;
    reg [DW:0] cap_word;
    reg cap_valid;
    reg [1:0] next_state;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [DW:0] buf_out_data;
    wire irq_edge;

    // Wait count of the space being accessed
    function [`EBR_WAIT_W-1:0] waits_of;
        input [1:0] sp;
        begin
            case (sp)
                `EBR_SPACE_BOOT: waits_of = boot_waits;
                `EBR_SPACE_PROG: waits_of = prog_waits;
                `EBR_SPACE_DATA: waits_of = data_waits;
                default: waits_of = io_waits;
            endcase
        end
    endfunction

    // One-hot active-low select for a space
    function [3:0] sel_of;
        input [1:0] sp;
        begin
            sel_of = `EBR_SEL_IDLE;
            sel_of[sp] = 1'b0;
        end
    endfunction

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    assign irq_edge = !irq_n && irq_d;

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (buf_in_ready && (irq_pend || req_valid))
                    next_state = ST_SETUP;
            ST_SETUP:
                next_state = ST_STROBE;
            ST_STROBE:
                if (wait_cnt == {`EBR_WAIT_W{1'b0}})
                    next_state = ST_DONE;
            ST_DONE:
                next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            wait_cnt <= {`EBR_WAIT_W{1'b0}};
            irq_d <= 1'b1;
            irq_pend <= 1'b0;
            cur_irq <= 1'b0;
            req_ready <= 1'b0;
            ext_addr <= {AW{1'b0}};
            rd_n <= 1'b1;
            boot_space_select_n <= 1'b1;
            program_space_select_n <= 1'b1;
            data_space_select_n <= 1'b1;
            io_space_select_n <= 1'b1;
            cap_word <= {(DW+1){1'b0}};
            cap_valid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            irq_d <= irq_n;
            req_ready <= 1'b0;
            cap_valid <= 1'b0;
            // New request wins over clearing of the pending flag
            if (irq_edge)
                irq_pend <= 1'b1;
            else if (state == ST_IDLE && next_state == ST_SETUP
                     && irq_pend)
                irq_pend <= 1'b0;
            case (state)
                ST_IDLE:
                    if (next_state == ST_SETUP)
                    begin
                        // Request line has priority over program reads
                        cur_irq <= irq_pend;
                        if (irq_pend)
                        begin
                            ext_addr <= irq_addr;
                            {io_space_select_n, data_space_select_n,
                             program_space_select_n,
                             boot_space_select_n} <=
                                sel_of(irq_space);
                            wait_cnt <= waits_of(irq_space);
                        end
                        else
                        begin
                            req_ready <= 1'b1;
                            ext_addr <= req_from_prog ? prog_addr
                                                      : data_addr;
                            {io_space_select_n, data_space_select_n,
                             program_space_select_n,
                             boot_space_select_n} <=
                                sel_of(req_space);
                            wait_cnt <= waits_of(req_space);
                        end
                    end
                ST_SETUP:
                    rd_n <= 1'b0;
                ST_STROBE:
                    // Whole-cycle strobe stands for the half-cycle base
                    if (wait_cnt != {`EBR_WAIT_W{1'b0}})
                        wait_cnt <= wait_cnt
                            - {{(`EBR_WAIT_W-1){1'b0}}, 1'b1};
                    else
                    begin
                        rd_n <= 1'b1;
                        ext_addr <= {AW{1'b0}};
                        boot_space_select_n <= 1'b1;
                        program_space_select_n <= 1'b1;
                        data_space_select_n <= 1'b1;
                        io_space_select_n <= 1'b1;
                        // Sampled as the strobe rises: peripheral still drives
                        cap_word <= {cur_irq, ext_data_in};
                        cap_valid <= 1'b1;
                    end
                default:
                    ;
            endcase
        end
    end

    // Entry reserved before start, so a captured word always fits
    ebr_buf #(
        .WIDTH(DW + 1)
    ) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(cap_valid),
        .in_ready(buf_in_ready),
        .in_data(cap_word),
        .out_valid(buf_out_valid),
        .out_ready(rdata_ready && rdata_valid || !rdata_valid),
        .out_data(buf_out_data)
    );

    // Output register stage keeps top outputs straight from flops
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_valid <= 1'b0;
            rdata <= {DW{1'b0}};
            rdata_from_irq <= 1'b0;
        end
        else if (!rdata_valid || rdata_ready)
        begin
            rdata_valid <= buf_out_valid;
            rdata <= buf_out_data[DW-1:0];
            rdata_from_irq <= buf_out_data[DW];
        end
    end
endmodule // ebr_read

// File: tb/ebr_read_assertions.sv
/*
 Port checker for the external bus read sequencer.
 Assumes it is bound onto ebr_read; one clock, active-low reset.
*/
`timescale 1ns/10ps
module ebr_read_chk (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Wait settings
    input wire [3:0] boot_waits, prog_waits, data_waits, io_waits,
    // External bus
    input wire rd_n,
    input wire [13:0] ext_addr,
    input wire boot_space_select_n, program_space_select_n,
    input wire data_space_select_n, io_space_select_n,
    // Handshakes
    input wire req_ready,
    input wire rdata_valid
);
    wire [3:0] sel = {io_space_select_n, data_space_select_n,
        program_space_select_n, boot_space_select_n};
    wire act = sel != 4'hF;
    reg [4:0] cnt;
    reg [3:0] w;
    always @*
    begin
        case (sel)
            4'hE: w = boot_waits;
            4'hD: w = prog_waits;
            4'hB: w = data_waits;
            default: w = io_waits;
        endcase
    end
    // Low-time counter; five bits since fifteen waits give sixteen cycles
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cnt <= 5'h00;
        else
            cnt <= rd_n ? 5'h00 : cnt + 5'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_setup;
        act && rd_n ##1 act && !rd_n;
    endsequence
    a_select_onehot: assert property ($onehot0(~sel))
        else $error("more than one space select low");
    a_strobe_setup: assert property ($rose(act) |-> s_setup)
        else $error("strobe not one cycle after select");
    a_strobe_width: assert property ($rose(rd_n) |->
        cnt == {1'b0, $past(w)} + 5'h01) else $error("strobe width");
    a_release_all: assert property ($rose(rd_n) |->
        !act && ext_addr == 14'h0000) else $error("release not together");
    a_wait_hold: assert property (!rd_n && !$past(rd_n) |->
        $stable(ext_addr) && $stable(sel)) else $error("bus moved in wait");
    a_strobe_select: assert property (!rd_n |-> act)
        else $error("strobe without select");
    a_ready_select: assert property (req_ready |->
        act && rd_n ##1 !rd_n) else $error("ready without select");
    a_data_result: assert property ($rose(rd_n) |-> ##2 rdata_valid)
        else $error("no result after strobe");
endmodule // ebr_read_chk

// File: tb/ebr_adc_model.sv
/*
 Converter model behind the address decoder.
 Assumes cs_en is the decoded chip select, enabled by any space select.
*/
`timescale 1ns/10ps
module ebr_adc_model #(
    parameter CONV = 6
) (
    // Clock and sampling pulse
    input wire clk,
    input wire convst,
    // Request line
    output reg irq_n,
    // Bus side
    input wire rd_n,
    input wire cs_en,
    input wire [13:0] addr,
    output reg [15:0] data
);
    integer n = -1;
    initial irq_n = 1'b1;
    initial data = 16'h0000;
    always @(posedge clk)
    begin
        if (convst)
            n <= CONV;
        else if (n > 0)
            n <= n - 1;
        if (n == 1)
            irq_n <= 1'b0;
        if (!rd_n && cs_en)
            irq_n <= 1'b1;
    end
    // Toggles when not driven, so a stale word reads inverted on every other clock and restored on the clocks between
    always @(posedge clk or negedge rd_n)
        data <= (!rd_n && cs_en) ? {2'h0, addr} ^ 16'hA5C3 : ~data;
endmodule // ebr_adc_model

// File: tb/tb_ebr_read.sv
/*
 Self-checking bench for the read sequencer.
 Assumes the converter model answers every selected strobe.
*/
`timescale 1ns/10ps
module tb_ebr_read;
    reg clk = 1'b0, resetn = 1'b0, convst = 1'b0, rdata_ready = 1'b1;
    reg req_valid = 1'b0, req_from_prog = 1'b0;
    reg [1:0] req_space = 2'h0, irq_space = 2'h3;
    reg [3:0] boot_waits = 4'h0, prog_waits = 4'hF;
    // Enough waits programmed for the slow spaces
    reg [3:0] data_waits = 4'h5, io_waits = 4'h1;
    reg [13:0] prog_addr = 14'h0000, data_addr = 14'h0000;
    reg [13:0] irq_addr = 14'h2AB5;
    wire req_ready, rd_n, rdata_valid, rdata_from_irq, irq_n;
    wire boot_space_select_n, program_space_select_n;
    wire data_space_select_n, io_space_select_n;
    wire [13:0] ext_addr;
    wire [15:0] ext_data_in, rdata;
    wire [3:0] sel = {io_space_select_n, data_space_select_n,
        program_space_select_n, boot_space_select_n};
    integer n_fail = 0, comparisons = 0, k;
    ebr_read u_dut (.clk, .resetn, .boot_waits, .prog_waits, .data_waits,
        .io_waits, .irq_n, .req_valid, .req_ready, .req_space,
        .req_from_prog, .prog_addr, .data_addr, .irq_addr, .irq_space,
        .ext_addr, .ext_data_in, .rd_n, .boot_space_select_n,
        .program_space_select_n, .data_space_select_n, .io_space_select_n,
        .rdata_valid, .rdata_ready, .rdata, .rdata_from_irq);
    ebr_adc_model u_adc (.clk, .convst, .irq_n, .rd_n,
        .cs_en(sel != 4'hF), .addr(ext_addr), .data(ext_data_in));
    initial forever #25 clk = ~clk;
    task check(input [63:0] what, input [15:0] got, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("BAD %0s exp %h got %h", what, exp, got);
        end
    end
    endtask
    task await(input [15:0] exp, input irq);
        integer t;
    begin
        t = 0;
        while (rdata_valid !== 1'b1 && t < 40)
        begin
            @(posedge clk) #1;
            t = t + 1;
        end
        check("valid", {15'h0, rdata_valid}, 16'h0001);
        check("rdata", rdata, exp);
        check("irqtag", {15'h0, rdata_from_irq}, {15'h0, irq});
        @(posedge clk) #1;
    end
    endtask
    task rd(input [1:0] sp, input pg, input [13:0] a);
        integer t;
    begin
        req_valid = 1'b1;
        req_space = sp;
        req_from_prog = pg;
        if (pg)
            prog_addr = a;
        else
            data_addr = a;
        t = 0;
        @(posedge clk) #1;
        while (req_ready !== 1'b1 && t < 20)
        begin
            @(posedge clk) #1;
            t = t + 1;
        end
        check("select", {12'h0, sel}, {12'h0, ~(4'h1 << sp)});
        check("addr", {2'h0, ext_addr}, {2'h0, a});
        @(posedge clk) #1;
        req_valid = 1'b0;
        await({2'h0, a} ^ 16'hA5C3, 1'b0);
    end
    endtask
    task t_spaces;
        for (k = 0; k < 4; k = k + 1)
            rd(k[1:0], k[0], 14'h3FFF ^ (k[13:0] * 14'h1111));
    endtask
    task t_irq;
    begin
        convst = 1'b1;
        @(posedge clk) #1;
        convst = 1'b0;
        await(16'h8F76, 1'b1);
    end
    endtask
    task t_stall;
        integer acc, got;
    begin
        acc = 0;
        got = 0;
        rdata_ready = 1'b0;
        rd_setup: data_addr = 14'h0155;
        req_space = 2'h2;
        req_from_prog = 1'b0;
        req_valid = 1'b1;
        repeat (60)
        begin
            @(posedge clk) #1;
            if (req_ready === 1'b1)
                acc = acc + 1;
        end
        req_valid = 1'b0;
        rdata_ready = 1'b1;
        while (rdata_valid === 1'b1 && got < 8)
        begin
            check("drain", rdata, 16'hA496);
            got = got + 1;
            @(posedge clk) #1;
        end
        check("kept", got[15:0], acc[15:0]);
        check("filled", {15'h0, acc >= 2}, 16'h0001);
    end
    endtask
    task end_of_test;
    begin
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_spaces;
        t_irq;
        t_stall;
        end_of_test;
    end
    initial
    begin
        #200000;
        n_fail = n_fail + 1;
        end_of_test;
    end
endmodule // tb_ebr_read
bind ebr_read ebr_read_chk u_chk (.clk, .resetn, .boot_waits, .prog_waits,
    .data_waits, .io_waits, .rd_n, .ext_addr, .boot_space_select_n,
    .program_space_select_n, .data_space_select_n, .io_space_select_n,
    .req_ready, .rdata_valid);
